// ===== rtl/cmc_top.sv
// Summary of operation
// - each comparator has a first control register with enable, result, invert, hysteresis and sync bits and a second with edge enables.
// - the enable bit runs the comparator; cleared, it is held idle with its result and pin outputs forced to 0.
// - enabling the second comparator also turns on the low-frequency oscillator that clocks it.
// - the result reads back in the comparator's control register and as a mirror bit in the summary register.
// - the internal result is latched every cycle; pin outputs are also registered every cycle unless sync is requested.
// - the invert bit flips the result ahead of the read bit, latch and pin path.
// - with invert off the result reads 1 when the negative input is below the positive input, else 0; invert swaps this.
// - with sync set, the pin output updates only on falling edges of the timer clock; the read result still updates every cycle.
//
// Purpose: register file and output control around two analog comparators
// Assumes: 10 MHz i_clock, raw compare results and timer clock asynchronous
// Notes: pin routing itself sits in the port logic outside this block
`timescale 1ns/1ns
`include "cmc_regs.svh"

module cmc_top
    import cmc_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_nrst,
    input wire logic [`CMC_ADDR_W-1:0] i_addr,
    input wire logic [`CMC_DATA_W-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [`CMC_DATA_W-1:0] o_rdata,
    input wire logic [`CMC_NUM_CMP-1:0] i_cmp_raw,
    input wire logic i_timer_clk,
    output logic [`CMC_NUM_CMP-1:0] o_cmp_pin,
    output logic [`CMC_NUM_CMP-1:0] o_cmp_enable,
    output logic [`CMC_NUM_CMP-1:0] o_cmp_hyst,
    output logic o_low_freq_internal_osc_en,
    output logic o_first_comparator_irq,
    output logic o_second_comparator_irq,
    output logic o_irq
);
    logic [`CMC_DATA_W-1:0] ctrl0_q [`CMC_NUM_CMP];
    logic [`CMC_DATA_W-1:0] ctrl1_q [`CMC_NUM_CMP];
    logic [`CMC_DATA_W-1:0] irq_en_q;
    logic [`CMC_NUM_CMP-1:0] stat_q;
    logic [`CMC_NUM_CMP-1:0] mask_q;
    logic [`CMC_NUM_CMP-1:0] result;
    logic [`CMC_NUM_CMP-1:0] edge_ev;
    logic [`CMC_DATA_W-1:0] rdata_q;
    logic [`CMC_DATA_W-1:0] rdata_d;

    genvar g;
    generate
        for (g = 0; g < `CMC_NUM_CMP; g++)
        begin : gen_cmp
            always_ff @(posedge i_clock or negedge i_nrst)
            begin
                if (!i_nrst)
                begin
                    ctrl0_q[g] <= `CMC_RESET_BYTE;
                    ctrl1_q[g] <= `CMC_RESET_BYTE;
                end
                else if (i_wr)
                begin
                    if (i_addr == `CMC_OFS_C1_CTRL0 + 4'(2 * g))
                        ctrl0_q[g] <= i_wdata & `CMC_CTRL0_WMASK;
                    if (i_addr == `CMC_OFS_C1_CTRL1 + 4'(2 * g))
                        ctrl1_q[g] <= i_wdata & `CMC_CTRL1_WMASK;
                end
            end

            cmc_channel u_chan (
                .i_clock(i_clock),
                .i_nrst(i_nrst),
                .i_enable(ctrl0_q[g][`CMC_CTRL0_ENABLE]),
                .i_invert(ctrl0_q[g][`CMC_CTRL0_INVERT]),
                .i_sync(ctrl0_q[g][`CMC_CTRL0_SYNC]),
                .i_rise_en(ctrl1_q[g][`CMC_CTRL1_RISE]),
                .i_fall_en(ctrl1_q[g][`CMC_CTRL1_FALL]),
                .i_raw(i_cmp_raw[g]),
                .i_timer_clk(i_timer_clk),
                .o_result(result[g]),
                .o_pin(o_cmp_pin[g]),
                .o_edge(edge_ev[g])
            );

            assign o_cmp_enable[g] = ctrl0_q[g][`CMC_CTRL0_ENABLE];
            assign o_cmp_hyst[g] = ctrl0_q[g][`CMC_CTRL0_HYST];

            always_ff @(posedge i_clock or negedge i_nrst)
            begin
                if (!i_nrst)
                    stat_q[g] <= 1'b0;
                else if (edge_ev[g])
                    stat_q[g] <= 1'b1;
                else if (i_wr && i_addr == `CMC_OFS_IRQ_STAT && i_wdata[g])
                    stat_q[g] <= 1'b0;
            end
        end
    endgenerate

    assign o_low_freq_internal_osc_en = ctrl0_q[1][`CMC_CTRL0_ENABLE];

    always_ff @(posedge i_clock or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            irq_en_q <= `CMC_RESET_BYTE;
            mask_q <= '0;
        end
        else if (i_wr)
        begin
            if (i_addr == `CMC_OFS_IRQ_EN)
                irq_en_q <= i_wdata & `CMC_IRQEN_WMASK;
            if (i_addr == `CMC_OFS_IRQ_MASK)
                mask_q <= i_wdata[`CMC_NUM_CMP-1:0];
        end
    end

    assign o_first_comparator_irq = stat_q[0] & irq_en_q[0];
    assign o_second_comparator_irq = stat_q[1] & irq_en_q[1];
    // level irq; a source needs both its mask and its enable bit set
    assign o_irq = |(stat_q & mask_q & irq_en_q[`CMC_NUM_CMP-1:0]);

    always_comb
    begin
        rdata_d = `CMC_RESET_BYTE;
        case (i_addr)
            `CMC_OFS_C1_CTRL0:
            begin
                rdata_d = ctrl0_q[0];
                rdata_d[`CMC_CTRL0_RESULT] = result[0];
            end
            `CMC_OFS_C1_CTRL1: rdata_d = ctrl1_q[0];
            `CMC_OFS_C2_CTRL0:
            begin
                rdata_d = ctrl0_q[1];
                rdata_d[`CMC_CTRL0_RESULT] = result[1];
            end
            `CMC_OFS_C2_CTRL1: rdata_d = ctrl1_q[1];
            `CMC_OFS_SUMMARY: rdata_d = {6'h00, result};
            `CMC_OFS_IRQ_EN: rdata_d = irq_en_q;
            `CMC_OFS_IRQ_STAT: rdata_d = {6'h00, stat_q};
            `CMC_OFS_IRQ_MASK: rdata_d = {6'h00, mask_q};
            default: rdata_d = `CMC_RESET_BYTE;
        endcase
    end

    // read data only in the cycle after the strobe
    always_ff @(posedge i_clock or negedge i_nrst)
    begin
        if (!i_nrst)
            rdata_q <= `CMC_RESET_BYTE;
        else if (i_rd)
            rdata_q <= rdata_d;
        else
            rdata_q <= `CMC_RESET_BYTE;
    end

    assign o_rdata = rdata_q;
endmodule

// ===== rtl/cmc_regs.svh
// Purpose: register offsets, field positions and reset values for the comparator output control
// Assumes: byte-wide registers on a plain strobe port
// Notes: included by the design files
`ifndef CMC_REGS_SVH
`define CMC_REGS_SVH

`define CMC_ADDR_W 4
`define CMC_DATA_W 8

`define CMC_OFS_C1_CTRL0 4'h0
`define CMC_OFS_C1_CTRL1 4'h1
`define CMC_OFS_C2_CTRL0 4'h2
`define CMC_OFS_C2_CTRL1 4'h3
`define CMC_OFS_SUMMARY 4'h4
`define CMC_OFS_IRQ_EN 4'h5
`define CMC_OFS_IRQ_STAT 4'h6
`define CMC_OFS_IRQ_MASK 4'h7

`define CMC_CTRL0_ENABLE 7
`define CMC_CTRL0_RESULT 6
`define CMC_CTRL0_INVERT 4
`define CMC_CTRL0_HYST 1
`define CMC_CTRL0_SYNC 0
`define CMC_CTRL0_WMASK 8'h93

`define CMC_CTRL1_RISE 1
`define CMC_CTRL1_FALL 0
`define CMC_CTRL1_WMASK 8'h03

`define CMC_IRQEN_ZCD 6
`define CMC_IRQEN_WMASK 8'h43

`define CMC_NUM_CMP 2
`define CMC_RESET_BYTE 8'h00

`endif

// ===== rtl/cmc_pkg.sv
// Purpose: shared types of the comparator output control
// Assumes: constants come from the register header
// Notes: one enum describes the pin path mode: off, async or sync
package cmc_pkg;
    typedef enum logic [1:0] {
        CMC_PATH_OFF,
        CMC_PATH_ASYNC,
        CMC_PATH_SYNC
    } cmc_path_t;
endpackage

// ===== rtl/cmc_channel.sv
// Purpose: one comparator output path: gating, polarity, latch, sync and edge detect
// Assumes: raw compare result and timer clock arrive asynchronously
// Notes: the first synchroniser flops feed only their second flops
`timescale 1ns/1ns
`include "cmc_regs.svh"

module cmc_channel
    import cmc_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_nrst,
    input wire logic i_enable,
    input wire logic i_invert,
    input wire logic i_sync,
    input wire logic i_rise_en,
    input wire logic i_fall_en,
    input wire logic i_raw,
    input wire logic i_timer_clk,
    output logic o_result,
    output logic o_pin,
    output logic o_edge
);
    logic raw_meta_q;
    logic raw_sync_q;
    logic tclk_meta_q;
    logic tclk_sync_q;
    logic tclk_prev_q;
    logic result_q;
    logic pin_q;
    logic pol_d;
    logic tclk_fall;
    cmc_path_t path_d;

    always_ff @(posedge i_clock or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            raw_meta_q <= 1'b0;
            raw_sync_q <= 1'b0;
            tclk_meta_q <= 1'b0;
            tclk_sync_q <= 1'b0;
            tclk_prev_q <= 1'b0;
        end
        else
        begin
            raw_meta_q <= i_raw;
            raw_sync_q <= raw_meta_q;
            tclk_meta_q <= i_timer_clk;
            tclk_sync_q <= tclk_meta_q;
            tclk_prev_q <= tclk_sync_q;
        end
    end

    assign pol_d = i_enable & (raw_sync_q ^ i_invert);
    assign tclk_fall = tclk_prev_q & ~tclk_sync_q;

    always_comb
    begin
        if (!i_enable)
            path_d = CMC_PATH_OFF;
        else if (i_sync)
            path_d = CMC_PATH_SYNC;
        else
            path_d = CMC_PATH_ASYNC;
    end

    always_ff @(posedge i_clock or negedge i_nrst)
    begin
        if (!i_nrst)
            result_q <= 1'b0;
        else
            result_q <= pol_d;
    end

    always_ff @(posedge i_clock or negedge i_nrst)
    begin
        if (!i_nrst)
            pin_q <= 1'b0;
        else
        begin
            case (path_d)
                CMC_PATH_OFF: pin_q <= 1'b0;
                CMC_PATH_SYNC:
                begin
                    if (tclk_fall)
                        pin_q <= pol_d;
                end
                CMC_PATH_ASYNC: pin_q <= pol_d;
                default: pin_q <= 1'b0;
            endcase
        end
    end

    assign o_result = result_q;
    assign o_pin = pin_q;
    assign o_edge = i_enable & ((i_rise_en & pol_d & ~result_q) | (i_fall_en & ~pol_d & result_q));
endmodule

// ===== tb/cmc_asserts.sv
// Purpose: port checker for cmc_top
// Assumes: one clock, async active-low reset
// Notes: bound at the foot of this file
`timescale 1ns/1ns
module cmc_asserts (
    input wire logic i_clock,
    input wire logic i_nrst,
    input wire logic [3:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [7:0] o_rdata,
    input wire logic [1:0] o_cmp_pin,
    input wire logic [1:0] o_cmp_enable,
    input wire logic [1:0] o_cmp_hyst,
    input wire logic o_low_freq_internal_osc_en,
    input wire logic o_first_comparator_irq,
    input wire logic o_irq
);
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_nrst);
    enable_write_a: assert property ($past(i_wr && i_addr == 4'h0) |-> o_cmp_enable[0] == $past(i_wdata[7]))
        else $error("first enable not taken from write");
    osc_enable_a: assert property ($past(i_wr && i_addr == 4'h2) |-> o_low_freq_internal_osc_en == $past(i_wdata[7]))
        else $error("oscillator enable does not follow second enable");
    hyst_write_a: assert property ($past(i_wr && i_addr == 4'h0) |-> o_cmp_hyst[0] == $past(i_wdata[1]))
        else $error("hysteresis bit not taken from write");
    pin_idle_a: assert property ((!o_cmp_enable[0]) [*3] |-> !o_cmp_pin[0])
        else $error("pin active while disabled");
    rdata_idle_a: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
        else $error("read data outside read answer");
    unmapped_zero_a: assert property ($past(i_rd && i_addr[3]) |-> o_rdata == 8'h00)
        else $error("unmapped read not zero");
    ctrl_reserved_a: assert property ($past(i_rd && i_addr == 4'h0) |-> (o_rdata & 8'h2c) == 8'h00)
        else $error("reserved control bits read nonzero");
    result_off_a: assert property ((!o_cmp_enable[0]) [*3] ##1 (i_rd && i_addr == 4'h0) |=> !o_rdata[6])
        else $error("result bit set while disabled");
    cover property (o_irq);
    cover property (o_cmp_pin[0]);
    cover property (o_first_comparator_irq && !o_irq);
endmodule
bind cmc_top cmc_asserts i_chk (.i_clock(i_clock), .i_nrst(i_nrst), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_cmp_pin(o_cmp_pin), .o_cmp_enable(o_cmp_enable),
    .o_cmp_hyst(o_cmp_hyst), .o_low_freq_internal_osc_en(o_low_freq_internal_osc_en),
    .o_first_comparator_irq(o_first_comparator_irq), .o_irq(o_irq));

// ===== tb/cmc_analog_model.sv
// Purpose: analog core stand-in and timer clock source
// Assumes: input levels are small unsigned codes
// Notes: a disabled core drives 0, its lowest-current state
`timescale 1ns/1ns
module cmc_analog_model (
    input wire logic [1:0] i_enable,
    input wire logic i_osc_en,
    input wire logic [15:0] i_levels,
    output logic [1:0] o_raw,
    output logic o_timer_clk
);
    initial o_timer_clk = 1'b0;
    // slow timer clock, 20 i_clock periods long, edges on falling edges of i_clock
    always #1000 o_timer_clk = ~o_timer_clk;
    always_comb
    begin
        o_raw[0] = i_enable[0] & (i_levels[7:4] > i_levels[3:0]);
        o_raw[1] = i_enable[1] & i_osc_en & (i_levels[15:12] > i_levels[11:8]);
    end
endmodule

// ===== tb/cmc_top_tb.sv
// Purpose: self-checking bench for cmc_top
// Assumes: 10 MHz clock, timer clock from the core model
// Notes: one task per scenario
`timescale 1ns/1ns
module cmc_top_tb;
    logic i_clock = 1'b0;
    logic i_nrst = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [15:0] levels = 16'h0000;
    logic [7:0] rdata, rv;
    logic [1:0] raw, pin, en, hyst;
    logic tclk, osc, irq1, irq2, irq;
    int failures = 0;
    int n_compared = 0;
    int cycles = 0;
    always #50 i_clock = ~i_clock;
    cmc_top i_dut (.i_clock(i_clock), .i_nrst(i_nrst), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
        .o_rdata(rdata), .i_cmp_raw(raw), .i_timer_clk(tclk), .o_cmp_pin(pin), .o_cmp_enable(en),
        .o_cmp_hyst(hyst), .o_low_freq_internal_osc_en(osc), .o_first_comparator_irq(irq1),
        .o_second_comparator_irq(irq2), .o_irq(irq));
    cmc_analog_model i_core (.i_enable(en), .i_osc_en(osc), .i_levels(levels), .o_raw(raw), .o_timer_clk(tclk));
    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge i_clock);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge i_clock);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [3:0] a);
        @(posedge i_clock);
        addr <= a;
        rd <= 1'b1;
        @(posedge i_clock);
        rd <= 1'b0;
        @(negedge i_clock);
        rv = rdata;
    endtask
    task automatic hold(input int n);
        repeat (n) @(posedge i_clock);
        @(negedge i_clock);
    endtask
    task automatic t_regs;
        for (int a = 0; a < 16; a++)
        begin
            rd_reg(a[3:0]);
            chk("reset", rv, 8'h00);
        end
        wr_reg(4'h1, 8'hff);
        rd_reg(4'h1);
        chk("ctrl1", rv, 8'h03);
        wr_reg(4'h5, 8'hff);
        rd_reg(4'h5);
        chk("irqen", rv, 8'h43);
        wr_reg(4'h1, 8'h00);
    endtask
    task automatic t_pol;
        logic inv, hi;
        for (int i = 0; i < 4; i++)
        begin
            inv = i[0];
            hi = i[1];
            wr_reg(4'h0, {3'h4, inv, 4'h0});
            levels <= hi ? 16'h0051 : 16'h0015;
            hold(4);
            chk("pin", {7'h0, pin[0]}, {7'h0, hi ^ inv});
            rd_reg(4'h0);
            chk("result", rv, {1'b1, hi ^ inv, 1'b0, inv, 4'h0});
            rd_reg(4'h4);
            chk("mirror", rv, {7'h0, hi ^ inv});
        end
    endtask
    task automatic t_second_comparator;
        wr_reg(4'h3, 8'h02);
        wr_reg(4'h2, 8'h82);
        levels <= 16'h5151;
        hold(4);
        chk("osc", {7'h0, osc}, 8'h01);
        chk("hyst", {6'h0, hyst}, 8'h02);
        chk("pins", {6'h0, pin}, 8'h02);
        chk("irq2", {6'h0, irq2, irq}, 8'h02);
        rd_reg(4'h2);
        chk("c2", rv, 8'hc2);
        wr_reg(4'h0, 8'h00);
        hold(4);
        chk("pinoff", {7'h0, pin[0]}, 8'h00);
        rd_reg(4'h4);
        chk("summary", rv, 8'h02);
        wr_reg(4'h2, 8'h00);
        hold(1);
        chk("oscoff", {7'h0, osc}, 8'h00);
    endtask
    task automatic t_irq;
        levels <= 16'h0015;
        wr_reg(4'h0, 8'h80);
        wr_reg(4'h1, 8'h02);
        wr_reg(4'h5, 8'h01);
        wr_reg(4'h7, 8'h01);
        wr_reg(4'h6, 8'hff);
        levels <= 16'h0051;
        hold(5);
        chk("irq", {5'h0, irq2, irq1, irq}, 8'h03);
        rd_reg(4'h6);
        chk("status", rv, 8'h01);
        wr_reg(4'h7, 8'h00);
        hold(2);
        chk("masked", {6'h0, irq1, irq}, 8'h02);
        wr_reg(4'h6, 8'h01);
        levels <= 16'h0015;
        hold(5);
        chk("cleared", {6'h0, irq1, irq}, 8'h00);
        rd_reg(4'h6);
        chk("nofall", rv, 8'h00);
    endtask
    task automatic t_sync;
        wr_reg(4'h0, 8'h81);
        @(posedge tclk);
        @(posedge i_clock);
        levels <= 16'h0051;
        hold(4);
        chk("held", {7'h0, pin[0]}, 8'h00);
        rd_reg(4'h0);
        chk("latched", rv, 8'hc1);
        @(negedge tclk);
        hold(5);
        chk("synced", {7'h0, pin[0]}, 8'h01);
    endtask
    task automatic wrap_up;
        $display("compared %0d mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    always @(posedge i_clock)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            failures++;
            wrap_up();
        end
    end
    initial
    begin
        repeat (8) @(posedge i_clock);
        i_nrst <= 1'b1;
        t_regs();
        t_pol();
        t_second_comparator();
        t_irq();
        t_sync();
        wrap_up();
    end
endmodule
